// ### verilog/pulse_gen_timer.sv
// Timer core in programmable pulse generation mode with Avalon-MM registers
//
// Operation
// - Start on selected trigger edge or on software command start.
// - Repeat select 0 gives continuous pulses, 1 gives a single shot.
// - Duty match inverts output, raises interrupt, counter keeps counting.
// - Continuous period match inverts output, interrupts, clears counter.
// - Start select cleared to 00 stops counting, output level held.
// - One-shot period match inverts, interrupts, clears start select, stops.
// - Output pin carries the inverse of the output flop.
// - Reset clears the output flop to 0.
// - Stopped with inverted level: init write loads inverse of value.
`timescale 1ns/10ps
module pulse_gen_timer import pulse_gen_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic trigger_input,
  output logic pulse_gen_output,
  output logic timer1_irq
);
  typedef struct packed {
    run_state_t state;
    logic [1:0] start_select;
    logic pulse_repeat_select;
    logic output_flop_init;
    logic [1:0] timer1_mode_select;
    logic [1:0] clk_sel;
    logic [15:0] period_compare;
    logic [15:0] duty_compare;
    logic [15:0] count;
    logic output_flop;
    logic inverted;
    logic out;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
    logic [2:0] trig;
  } core_t;

  core_t r;
  core_t next_r;
  source_tick_if ts ();

  logic tick;
  logic trig_edge;
  logic done;
  logic duty_hit;
  logic period_hit;
  logic [1:0] new_start;
  logic [1:0] new_mode;
  logic [1:0] events;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0])
      v[7:0] = wd[7:0];
    if (be[1])
      v[15:8] = wd[15:8];
    return v;
  endfunction

  source_prescaler u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .ts(ts.gen)
  );

  assign ts.sel = r.clk_sel;
  assign tick = ts.tick;

  always_comb
  begin
    next_r = r;
    events = 2'h0;
    // Only the second synchroniser stage and its delayed copy are compared
    next_r.trig = {r.trig[1:0], trigger_input};
    trig_edge = (r.start_select == START_RISE) ? (r.trig[1] & ~r.trig[2])
                                               : (~r.trig[1] & r.trig[2]);
    done = (read | write) & ~r.waitreq;
    duty_hit = (r.state == ST_RUN) && tick && (r.count == r.duty_compare);
    period_hit = (r.state == ST_RUN) && tick
                 && (r.count == r.period_compare);
    new_start = writedata[START_LSB +: 2];
    new_mode = writedata[MODE_LSB +: 2];

    // Counting and compare
    if (r.state == ST_ARMED && trig_edge)
    begin
      next_r.state = ST_RUN;
      next_r.count = 16'h0000;
    end
    if (period_hit)
    begin
      next_r.output_flop = ~r.output_flop;
      next_r.inverted = ~r.inverted;
      next_r.count = 16'h0000;
      events[IRQ_PERIOD_BIT] = 1'b1;
      if (r.pulse_repeat_select)
      begin
        next_r.start_select = START_STOP;
        next_r.state = ST_IDLE;
      end
    end
    else if (r.state == ST_RUN && tick)
    begin
      next_r.count = r.count + 16'h0001;
      if (duty_hit)
      begin
        next_r.output_flop = ~r.output_flop;
        next_r.inverted = ~r.inverted;
        events[IRQ_DUTY_BIT] = 1'b1;
      end
    end

    // Avalon slave: first cycle latches read data, second completes
    if ((read | write) && r.waitreq)
    begin
      next_r.waitreq = 1'b0;
      unique case (address)
        OFS_CONTROL: next_r.rdata = {24'h00_0000, r.clk_sel,
                                     r.timer1_mode_select,
                                     r.output_flop_init,
                                     r.pulse_repeat_select,
                                     r.start_select};
        OFS_PERIOD: next_r.rdata = {16'h0000, r.period_compare};
        OFS_DUTY: next_r.rdata = {16'h0000, r.duty_compare};
        OFS_STATUS: next_r.rdata = {30'h0000_0000, r.status};
        OFS_MASK: next_r.rdata = {30'h0000_0000, r.mask};
        OFS_COUNT: next_r.rdata = {16'h0000, r.count};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    else if (done)
    begin
      next_r.waitreq = 1'b1;
      // Clear only what the read returned, so a later set survives
      if (read && address == OFS_STATUS)
        next_r.status = r.status & ~r.rdata[1:0];
      if (write)
      begin
        unique case (address)
          OFS_PERIOD:
            next_r.period_compare = merge16(r.period_compare, writedata,
                                            byteenable);
          OFS_DUTY:
            next_r.duty_compare = merge16(r.duty_compare, writedata,
                                          byteenable);
          OFS_MASK:
            if (byteenable[0])
              next_r.mask = writedata[1:0];
          OFS_CONTROL:
            if (byteenable[0])
            begin
              next_r.start_select = new_start;
              next_r.pulse_repeat_select = writedata[REPEAT_BIT];
              next_r.output_flop_init = writedata[INIT_BIT];
              next_r.timer1_mode_select = new_mode;
              next_r.clk_sel = writedata[CLKSEL_LSB +: 2];
              if (new_mode != MODE_PULSE)
                next_r.state = ST_IDLE;
              else if (r.timer1_mode_select != MODE_PULSE)
              begin
                // Entering pulse mode reinitialises the flop
                next_r.output_flop = writedata[INIT_BIT];
                next_r.inverted = 1'b0;
              end
              else if (r.state != ST_RUN)
                next_r.output_flop = r.inverted ? ~writedata[INIT_BIT]
                                                : writedata[INIT_BIT];
              if (new_mode == MODE_PULSE)
              begin
                if (new_start == START_STOP)
                  next_r.state = ST_IDLE;
                else if (r.state == ST_IDLE && new_start == START_CMD)
                begin
                  next_r.state = ST_RUN;
                  next_r.count = 16'h0000;
                end
                else if (r.state == ST_IDLE)
                  next_r.state = ST_ARMED;
              end
            end
          default: ;
        endcase
      end
    end

    // A match in the clearing cycle still sets its bit
    next_r.status = next_r.status | events;
    next_r.irq = |(next_r.status & next_r.mask);
    next_r.out = ~next_r.output_flop;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.period_compare <= PERIOD_RESET;
      r.duty_compare <= DUTY_RESET;
      r.mask <= MASK_RESET;
      r.output_flop <= 1'b0;
      r.out <= 1'b1;
      r.waitreq <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign readdata = r.rdata;
  assign waitrequest = r.waitreq;
  assign pulse_gen_output = r.out;
  assign timer1_irq = r.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_flop_clear: assert property (
    $rose(rst_n) |-> (r.output_flop == 1'b0) && pulse_gen_output)
    else $error("output flop not cleared by reset");

  a_pin_inverse: assert property (
    ##1 (pulse_gen_output == ~r.output_flop))
    else $error("pulse output is not the inverse of the flop");

  a_count_step: assert property (
    (r.state == ST_RUN && tick && r.count != r.period_compare
     && !done)
    |=> r.count == $past(r.count) + 16'h0001)
    else $error("counter did not advance on source tick");

  a_duty_toggle: assert property (
    (duty_hit && r.count != r.period_compare && !(done && write))
    |=> (pulse_gen_output != $past(pulse_gen_output))
        && r.status[IRQ_DUTY_BIT] && r.state == ST_RUN)
    else $error("duty match did not toggle and interrupt");

  a_period_wrap: assert property (
    (period_hit && !r.pulse_repeat_select && !(done && write))
    |=> r.count == 16'h0000 && r.state == ST_RUN
        && r.status[IRQ_PERIOD_BIT]
        && pulse_gen_output != $past(pulse_gen_output))
    else $error("continuous period match misbehaved");

  a_oneshot_stop: assert property (
    (period_hit && r.pulse_repeat_select && !(done && write))
    |=> r.state == ST_IDLE && r.start_select == START_STOP
        ##1 (r.state == ST_IDLE || $past(done && write)))
    else $error("one-shot did not stop after period match");

  a_stop_holds: assert property (
    ((r.state == ST_IDLE || (r.state == ST_ARMED && !trig_edge))
     && !(done && write))
    |=> $stable(pulse_gen_output) && $stable(r.count))
    else $error("stopped timer changed count or output");

  a_cmd_start: assert property (
    (done && write && address == OFS_CONTROL && byteenable[0]
     && new_mode == MODE_PULSE && new_start == START_CMD
     && r.state == ST_IDLE)
    |=> r.state == ST_RUN && r.count == 16'h0000)
    else $error("command start did not start the counter");

  a_edge_start: assert property (
    (r.state == ST_ARMED && trig_edge && !(done && write))
    |=> r.state == ST_RUN)
    else $error("trigger edge did not start the counter");

  a_reinit_inverse: assert property (
    (done && write && address == OFS_CONTROL && byteenable[0]
     && r.state != ST_RUN && r.inverted
     && r.timer1_mode_select == MODE_PULSE && new_mode == MODE_PULSE)
    |=> r.output_flop == ~$past(writedata[INIT_BIT]))
    else $error("flop init write after inverted stop not inverted");

  a_irq_level: assert property (
    ##1 (timer1_irq == |(r.status & r.mask)))
    else $error("interrupt output disagrees with status and mask");

  a_status_sticky: assert property (
    (|events) |=> ((r.status & $past(events)) == $past(events)))
    else $error("match event not kept in status");

  a_idle_no_start: assert property (
    (r.state == ST_IDLE && !(done && write)) |=> r.state == ST_IDLE)
    else $error("stopped timer started without a command");
endmodule

// ### verilog/pulse_gen_pkg.sv
// Constants and types shared by the programmable pulse generator
package pulse_gen_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_PERIOD = 5'h04;
  localparam logic [4:0] OFS_DUTY = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_COUNT = 5'h14;

  // timer1_control field positions
  localparam int START_LSB = 0;
  localparam int REPEAT_BIT = 2;
  localparam int INIT_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int CLKSEL_LSB = 6;

  // start_select codes
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;

  // timer1_mode_select codes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;

  // Status and mask bit positions
  localparam int IRQ_DUTY_BIT = 0;
  localparam int IRQ_PERIOD_BIT = 1;

  // Reset values
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Source clock prescaler masks: divide by 2^11, 2^7, 2^5, 2^3
  localparam logic [10:0] DIV_MASK_11 = 11'h7ff;
  localparam logic [10:0] DIV_MASK_7 = 11'h07f;
  localparam logic [10:0] DIV_MASK_5 = 11'h01f;
  localparam logic [10:0] DIV_MASK_3 = 11'h007;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} run_state_t;
endpackage

// ### verilog/source_tick_if.sv
// Source clock select and tick between timer core and prescaler
`timescale 1ns/10ps
interface source_tick_if;
  logic [1:0] sel;
  logic tick;
  modport gen (input sel, output tick);
  modport use_tick (output sel, input tick);
endinterface

// ### verilog/source_prescaler.sv
// Prescaler that makes the internal source clock tick
`timescale 1ns/10ps
module source_prescaler import pulse_gen_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  source_tick_if.gen ts
);
  typedef struct packed {
    logic [10:0] cnt;
    logic tick;
  } presc_t;

  presc_t r;
  presc_t next_r;
  logic [10:0] mask;

  always_comb
  begin
    unique case (ts.sel)
      2'h0: mask = DIV_MASK_11;
      2'h1: mask = DIV_MASK_7;
      2'h2: mask = DIV_MASK_5;
      2'h3: mask = DIV_MASK_3;
    endcase
    next_r = r;
    next_r.cnt = r.cnt + 11'h001;
    next_r.tick = ((r.cnt & mask) == mask);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign ts.tick = r.tick;
endmodule

// ### verification/trigger_load.sv
// Far-side model: drives the trigger pin and counts output toggles
`timescale 1ns/10ps
module trigger_load (
  input wire logic clk,
  input wire logic want_level,
  input wire logic pulse_gen_output,
  output logic trigger_input,
  output logic [7:0] toggles
);
  logic [1:0] hold;
  logic last_out;
  initial
  begin
    trigger_input = 1'b0;
    hold = 2'h0;
    toggles = 8'h00;
    last_out = 1'b1;
  end
  always @(posedge clk)
  begin
    // Each level stays 3 clocks or more so the synchroniser sees it
    if (hold != 2'h0)
      hold <= hold - 2'h1;
    else if (want_level != trigger_input)
    begin
      trigger_input <= want_level;
      hold <= 2'h3;
    end
    if (pulse_gen_output !== last_out)
      toggles <= toggles + 8'h01;
    last_out <= pulse_gen_output;
  end
endmodule

// ### verification/pulse_gen_timer_test.sv
// Self-checking testbench for the programmable pulse generator
`timescale 1ns/10ps
module pulse_gen_timer_test import pulse_gen_pkg::*;;
  logic clk, rst_n, read, write, want_level, trigger_input;
  logic waitrequest, pulse_gen_output, timer1_irq;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [7:0] toggles, t0;
  int fails, comparisons, cycles, n1, n2;

  pulse_gen_timer u_pulse_gen_timer (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .trigger_input(trigger_input),
    .pulse_gen_output(pulse_gen_output), .timer1_irq(timer1_irq));
  trigger_load u_trigger_load (.clk(clk), .want_level(want_level),
    .pulse_gen_output(pulse_gen_output), .trigger_input(trigger_input),
    .toggles(toggles));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Runs take well under a thousand cycles; this ceiling only cuts a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] st,
    input logic rep, input logic ini, input logic [1:0] md);
    return {24'h00_0000, 2'h3, md, ini, rep, st};
  endfunction

  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    // Ends when waitrequest drops; only the bench timeout cuts a hang
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic wait_out(input logic lvl, output int n);
    n = 0;
    while (pulse_gen_output !== lvl)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_reset();
    pin(pulse_gen_output, 1'b1);
    pin(timer1_irq, 1'b0);
    rd(OFS_PERIOD, {16'h0, PERIOD_RESET});
    rd(OFS_DUTY, {16'h0, DUTY_RESET});
    rd(OFS_MASK, {30'h0, MASK_RESET});
    rd(5'h18, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_cont();
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b0, MODE_PULSE));
    wr(OFS_PERIOD, 32'h0000_0005);
    wr(OFS_DUTY, 32'h0000_0002);
    wr(OFS_MASK, 32'h0000_0003);
    wr(OFS_CONTROL, ctl(START_CMD, 1'b0, 1'b0, MODE_PULSE));
    wait_out(1'b0, n1);
    wait_out(1'b1, n1);
    wait_out(1'b0, n2);
    // Period moved well above the count; the stop lands before the next tick
    wr(OFS_PERIOD, 32'h0000_0010);
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b0, MODE_PULSE));
    t0 = toggles;
    check(32'(n1), 32'h0000_0018);
    check(32'(n1 + n2), 32'h0000_0030);
    repeat (60) @(posedge clk);
    check({24'h0, toggles}, {24'h0, t0});
    pin(pulse_gen_output, 1'b0);
    pin(timer1_irq, 1'b1);
    rd(OFS_STATUS, 32'h0000_0003);
    repeat (2) @(posedge clk);
    pin(timer1_irq, 1'b0);
    rd(OFS_COUNT, 32'h0000_0003);
    rd(OFS_PERIOD, 32'h0000_0010);
    wr(OFS_PERIOD, 32'h0000_0005);
    $display("continuous test done");
  endtask

  task automatic t_flop();
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b1, MODE_PULSE));
    repeat (2) @(posedge clk);
    pin(pulse_gen_output, 1'b1);
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b0, MODE_TIMER));
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b1, MODE_PULSE));
    repeat (2) @(posedge clk);
    pin(pulse_gen_output, 1'b0);
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b0, MODE_TIMER));
    wr(OFS_CONTROL, ctl(START_STOP, 1'b0, 1'b0, MODE_PULSE));
    repeat (2) @(posedge clk);
    pin(pulse_gen_output, 1'b1);
    $display("flop test done");
  endtask

  task automatic t_oneshot();
    wr(OFS_MASK, 32'h0);
    wr(OFS_CONTROL, ctl(START_RISE, 1'b1, 1'b0, MODE_PULSE));
    t0 = toggles;
    repeat (40) @(posedge clk);
    check({24'h0, toggles}, {24'h0, t0});
    want_level <= 1'b1;
    wait_out(1'b0, n1);
    wait_out(1'b1, n1);
    check(32'(n1), 32'h0000_0018);
    repeat (80) @(posedge clk);
    check({24'h0, toggles - t0}, 32'h0000_0002);
    rd(OFS_CONTROL, ctl(START_STOP, 1'b1, 1'b0, MODE_PULSE));
    pin(timer1_irq, 1'b0);
    rd(OFS_STATUS, 32'h0000_0003);
    // Slower source clock here: one tick every 32 cycles
    wr(OFS_CONTROL,
       ctl(START_FALL, 1'b1, 1'b0, MODE_PULSE) & 32'hffff_ffbf);
    want_level <= 1'b0;
    wait_out(1'b0, n1);
    wait_out(1'b1, n1);
    check(32'(n1), 32'h0000_0060);
    rd(OFS_CONTROL,
       ctl(START_STOP, 1'b1, 1'b0, MODE_PULSE) & 32'hffff_ffbf);
    $display("one-shot test done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    want_level = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cont();
    t_flop();
    t_oneshot();
    report_and_stop();
  end
endmodule
